// ---- irs_ctrl_model.sv ----
// Behavioural I2C controller issuing register reads to the sequencer.
// Assumes a pull-up on SDA; the device only ever pulls the wire low.
`timescale 1ns/1ps
`default_nettype none

module irs_ctrl_model (
    // Clock
    input  wire logic clk_sys,
    // Bus lines
    input  wire logic sdaOe,
    output logic      sclLine,
    output logic      sdaLine
);
    import irs_pkg::*;
    // Slow enough for the device's two-flop pin synchronisers
    localparam int HALF = 20;

    logic       mstPull;
    logic [2:0] acks;
    logic       nackOe;
    logic [7:0] rxBuf [0:31];

    // A released wire floats high through the pull-up
    assign sdaLine = ~(mstPull | sdaOe);

    initial begin
        sclLine = 1'b1;
        mstPull = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Data moves a few clocks after SCL falls, never beside the edge
    task automatic bit_cycle(input logic b, output logic s);
        wait_clk(4);
        mstPull = ~b;
        wait_clk(HALF);
        sclLine = 1'b1;
        wait_clk(HALF);
        s = sdaLine;
        sclLine = 1'b0;
    endtask

    task automatic start_cond();
        wait_clk(4);
        mstPull = 1'b0;
        wait_clk(HALF);
        sclLine = 1'b1;
        wait_clk(HALF);
        mstPull = 1'b1;
        wait_clk(HALF);
        sclLine = 1'b0;
    endtask

    task automatic stop_cond();
        wait_clk(4);
        mstPull = 1'b1;
        wait_clk(HALF);
        sclLine = 1'b1;
        wait_clk(HALF);
        mstPull = 1'b0;
        wait_clk(HALF);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], s);
        end
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic ackIt, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            d[i] = s;
        end
        bit_cycle(~ackIt, s);
    endtask

    task automatic read_regs(input logic [7:0] hdr, input logic [7:0] addr,
                             input int n);
        start_cond();
        send_byte({hdr[7:1], 1'b0}, acks[2]);
        send_byte(addr, acks[1]);
        start_cond();
        send_byte({hdr[7:1], 1'b1}, acks[0]);
        for (int k = 0; k < n; k++) begin
            recv_byte(k < n - 1, rxBuf[k]);
        end
        wait_clk(HALF);
        nackOe = sdaOe;
        stop_cond();
    endtask
endmodule

`default_nettype wire

// ---- irs_pkg.sv ----
// Shared constants and types for the I2C register read sequencer.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
`default_nettype none

package irs_pkg;
    // Device-type code of the header byte; value is arbitrary
    localparam logic [3:0] IRS_TYPE_CODE  = 4'h6;
    localparam logic [7:0] IRS_ADDR_FIRST = 8'h00;
    localparam logic [7:0] IRS_ADDR_WIPER = 8'h03;
    localparam logic [7:0] IRS_ADDR_LAST  = 8'h0F;
    localparam logic [7:0] IRS_ADDR_ACR   = 8'h10;
    localparam int         IRS_ACR_VOL    = 7;
    localparam logic [7:0] IRS_ACR_RESET  = 8'h40;
    localparam logic [7:0] IRS_ACR_WMASK  = 8'hC0;
    localparam logic [3:0] IRS_BIT_LAST   = 4'h7;
    localparam logic [3:0] IRS_BIT_FULL   = 4'h8;
    localparam logic [3:0] IRS_BIT_ZERO   = 4'h0;
    localparam int         IRS_NUM_LOC    = 16;
    localparam int         IRS_NUM_WIPER  = 4;
    localparam int         IRS_LOAD_W     = 16;
    localparam int         IRS_FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RX     = 3'b001,
        ST_RXACK  = 3'b010,
        ST_TX     = 3'b011,
        ST_TXACK  = 3'b100,
        ST_TXNEXT = 3'b101,
        ST_WAIT   = 3'b110
    } irs_state_t;

    typedef enum logic [1:0] {
        STG_HDR  = 2'b00,
        STG_ADDR = 2'b01,
        STG_RHDR = 2'b10
    } irs_stage_t;
endpackage

`default_nettype wire

// ---- irs_read_sequencer.sv ----
// I2C target read sequencer with its byte register file and load FIFO.
// Assumes SCL/SDA and address-select pins arrive asynchronously; an outer
// pad resolves the open-drain SDA wire from sdaOut/sdaOe.
//
// Overview of operation
// - Acknowledge the write header, the address byte and the read header.
// - Keep sending data bytes while the controller acknowledges each byte.
// - Data comes from the pointed register; address byte loads the pointer.
// - Pointer advances by one for each data byte sent.
// - Pointer rolls from 0Fh, or from any higher address, to 00h and streaming continues.
// - Header accepted only if type code and select pins match.
// - Bytes travel most significant bit first.
// - Select bit chooses wiper or initial registers at addresses 0 to 3.
`timescale 1ns/1ps
`default_nettype none

module irs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wrPtr;
        logic [PW-1:0]               rdPtr;
        logic [CW-1:0]               count;
        logic                        full;
    } irs_fifo_t;

    irs_fifo_t st_ff, nxt_st;
    logic      push, pop;

    assign push     = inValid & ~st_ff.full;
    assign pop      = outReady & (st_ff.count != '0);
    assign inReady  = ~st_ff.full;
    assign outValid = st_ff.count != '0;
    assign outData  = st_ff.mem[st_ff.rdPtr];

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wrPtr] = inData;
            nxt_st.wrPtr = st_ff.wrPtr + 1'b1;
        end
        if (pop) begin
            nxt_st.rdPtr = st_ff.rdPtr + 1'b1;
        end
        nxt_st.count = st_ff.count + CW'(push) - CW'(pop);
        nxt_st.full  = nxt_st.count == FULL_CNT;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

module irs_read_sequencer (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Serial link pins
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // Address-select straps
    input  wire logic       addr_select_pin_2,
    input  wire logic       addr_select_pin_1,
    input  wire logic       addr_select_pin_0,
    // Register load port from the write path
    input  wire logic       loadValid,
    output logic            loadReady,
    input  wire logic [7:0] loadAddr,
    input  wire logic [7:0] loadData,
    // Status
    output logic            readActive
);
    import irs_pkg::*;

    typedef struct packed {
        irs_state_t                          state;
        irs_stage_t                          stage;
        logic [3:0]                          bitCnt;
        logic [7:0]                          shift;
        logic [7:0]                          ptr;
        logic                                ptrLoaded;
        logic                                sdaOe;
        logic                                readActive;
        logic                                sclMeta, sclSync, sclPrev;
        logic                                sdaMeta, sdaSync, sdaPrev;
        logic [2:0]                          selMeta, selSync;
        logic [7:0]                          access_control_reg;
        logic [IRS_NUM_LOC-1:0][7:0]         mem;
        logic [IRS_NUM_WIPER-1:0][7:0]       wiper;
    } irs_seq_t;

    irs_seq_t               st_ff, nxt_st;
    logic                   sclRise, sclFall, startCond, stopCond;
    logic                   ackOk, loadEv, drain, fifoValid;
    logic [IRS_LOAD_W-1:0]  fifoData;
    logic [7:0]             wAddr, wData, txByte;

    function automatic logic [7:0] readReg(irs_seq_t s, logic [7:0] a);
        if (a == IRS_ADDR_ACR)
            return s.access_control_reg;
        else if (a <= IRS_ADDR_WIPER && s.access_control_reg[IRS_ACR_VOL])
            return s.wiper[a[1:0]];
        else if (a <= IRS_ADDR_LAST)
            return s.mem[a[3:0]];
        return '0;
    endfunction

    function automatic logic [7:0] nextPtr(logic [7:0] p);
        return (p >= IRS_ADDR_LAST) ? IRS_ADDR_FIRST : p + 8'h01;
    endfunction

    // Edges are taken only from the second synchroniser stage onward
    assign sclRise   = st_ff.sclSync & ~st_ff.sclPrev;
    assign sclFall   = ~st_ff.sclSync & st_ff.sclPrev;
    assign startCond = st_ff.sclSync & st_ff.sclPrev & st_ff.sdaPrev
                       & ~st_ff.sdaSync;
    assign stopCond  = st_ff.sclSync & st_ff.sclPrev & ~st_ff.sdaPrev
                       & st_ff.sdaSync;

    always_comb begin
        case (st_ff.stage)
            STG_HDR:  ackOk = st_ff.shift[7:1] ==
                              {IRS_TYPE_CODE, st_ff.selSync}
                              && !st_ff.shift[0];
            STG_ADDR: ackOk = 1'b1;
            STG_RHDR: ackOk = st_ff.shift[7:1] ==
                              {IRS_TYPE_CODE, st_ff.selSync}
                              && st_ff.shift[0];
            default:  ackOk = 1'b0;
        endcase
    end

    assign loadEv = sclFall && !startCond && !stopCond
                    && ((st_ff.state == ST_RXACK && st_ff.stage == STG_RHDR)
                        || st_ff.state == ST_TXNEXT);
    // Register writes stall while a byte is fetched for transmission
    assign drain  = fifoValid & ~loadEv;
    assign wAddr  = fifoData[15:8];
    assign wData  = fifoData[7:0];
    assign txByte = readReg(st_ff, st_ff.ptr);

    irs_fifo #(
        .WIDTH (IRS_LOAD_W),
        .DEPTH (IRS_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .inValid  (loadValid),
        .inReady  (loadReady),
        .inData   ({loadAddr, loadData}),
        .outValid (fifoValid),
        .outReady (~loadEv),
        .outData  (fifoData)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sclMeta = sclIn;
        nxt_st.sclSync = st_ff.sclMeta;
        nxt_st.sclPrev = st_ff.sclSync;
        nxt_st.sdaMeta = sdaIn;
        nxt_st.sdaSync = st_ff.sdaMeta;
        nxt_st.sdaPrev = st_ff.sdaSync;
        nxt_st.selMeta = {addr_select_pin_2, addr_select_pin_1,
                          addr_select_pin_0};
        nxt_st.selSync = st_ff.selMeta;
        if (drain) begin
            // A write to an initial register also updates its wiper
            if (wAddr <= IRS_ADDR_WIPER) begin
                nxt_st.wiper[wAddr[1:0]] = wData;
                if (!st_ff.access_control_reg[IRS_ACR_VOL])
                    nxt_st.mem[wAddr[3:0]] = wData;
            end else if (wAddr <= IRS_ADDR_LAST) begin
                nxt_st.mem[wAddr[3:0]] = wData;
            end else if (wAddr == IRS_ADDR_ACR) begin
                nxt_st.access_control_reg = wData & IRS_ACR_WMASK;
            end
        end
        if (startCond) begin
            nxt_st.state  = ST_RX;
            nxt_st.bitCnt = IRS_BIT_ZERO;
            nxt_st.sdaOe  = 1'b0;
            nxt_st.stage  = st_ff.ptrLoaded ? STG_RHDR : STG_HDR;
        end else if (stopCond) begin
            nxt_st.state      = ST_IDLE;
            nxt_st.sdaOe      = 1'b0;
            nxt_st.ptrLoaded  = 1'b0;
            nxt_st.readActive = 1'b0;
        end else if (loadEv) begin
            nxt_st.shift      = txByte;
            nxt_st.sdaOe      = ~txByte[7];
            nxt_st.ptr        = nextPtr(st_ff.ptr);
            nxt_st.bitCnt     = IRS_BIT_ZERO;
            nxt_st.state      = ST_TX;
            nxt_st.readActive = 1'b1;
        end else begin
            case (st_ff.state)
                ST_RX: begin
                    if (sclRise && st_ff.bitCnt < IRS_BIT_FULL) begin
                        nxt_st.shift  = {st_ff.shift[6:0], st_ff.sdaSync};
                        nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
                    end else if (sclFall && st_ff.bitCnt == IRS_BIT_FULL) begin
                        if (ackOk) begin
                            nxt_st.sdaOe = 1'b1;
                            nxt_st.state = ST_RXACK;
                            if (st_ff.stage == STG_ADDR)
                                nxt_st.ptr = st_ff.shift;
                        end else begin
                            nxt_st.state = ST_WAIT;
                        end
                    end
                end
                ST_RXACK: begin
                    if (sclFall) begin
                        nxt_st.sdaOe  = 1'b0;
                        nxt_st.bitCnt = IRS_BIT_ZERO;
                        if (st_ff.stage == STG_HDR) begin
                            nxt_st.stage = STG_ADDR;
                            nxt_st.state = ST_RX;
                        end else begin
                            // Write data bytes belong to the write path
                            nxt_st.ptrLoaded = 1'b1;
                            nxt_st.state     = ST_WAIT;
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        if (st_ff.bitCnt == IRS_BIT_LAST) begin
                            nxt_st.sdaOe = 1'b0;
                            nxt_st.state = ST_TXACK;
                        end else begin
                            nxt_st.shift  = {st_ff.shift[6:0], 1'b0};
                            nxt_st.sdaOe  = ~st_ff.shift[6];
                            nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
                        end
                    end
                end
                ST_TXACK: begin
                    if (sclRise) begin
                        if (st_ff.sdaSync) begin
                            nxt_st.state      = ST_WAIT;
                            nxt_st.readActive = 1'b0;
                        end else begin
                            nxt_st.state = ST_TXNEXT;
                        end
                    end
                end
                ST_IDLE, ST_TXNEXT, ST_WAIT: nxt_st.sdaOe = 1'b0;
                default: nxt_st.state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff       <= '0;
            st_ff.access_control_reg   <= IRS_ACR_RESET;
            st_ff.state <= ST_IDLE;
            st_ff.stage <= STG_HDR;
            // Pins idle high; a low reset value would fake an SCL edge
            {st_ff.sclMeta, st_ff.sclSync, st_ff.sclPrev} <= '1;
            {st_ff.sdaMeta, st_ff.sdaSync, st_ff.sdaPrev} <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Open drain: the pin is only ever pulled low
    assign sdaOut     = 1'b0 & st_ff.sdaOe;
    assign sdaOe      = st_ff.sdaOe;
    assign readActive = st_ff.readActive;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_byteDone;
        st_ff.state == ST_RX && st_ff.bitCnt == IRS_BIT_FULL && sclFall
        && !startCond && !stopCond;
    endsequence
    sequence s_ackGood;
        st_ff.state == ST_TXACK && sclRise && !st_ff.sdaSync
        && !startCond && !stopCond;
    endsequence

    property p_ackAddr;
        s_byteDone and st_ff.stage == STG_ADDR
        |=> sdaOe && st_ff.state == ST_RXACK;
    endproperty
    a_ackAddr: assert property (p_ackAddr)
        else $error("address byte not acknowledged");

    property p_hdrReject;
        s_byteDone and st_ff.stage == STG_HDR
        and st_ff.shift[7:1] != {IRS_TYPE_CODE, st_ff.selSync}
        |=> !sdaOe ##1 !sdaOe;
    endproperty
    a_hdrReject: assert property (p_hdrReject)
        else $error("foreign header acknowledged");

    property p_ptrLoad;
        s_byteDone and st_ff.stage == STG_ADDR
        |=> st_ff.ptr == $past(st_ff.shift);
    endproperty
    a_ptrLoad: assert property (p_ptrLoad)
        else $error("pointer not loaded from address byte");

    property p_ptrInc;
        loadEv && st_ff.ptr < IRS_ADDR_LAST
        |=> st_ff.ptr == $past(st_ff.ptr) + 8'h01;
    endproperty
    a_ptrInc: assert property (p_ptrInc)
        else $error("pointer did not advance by one");

    property p_ptrWrap;
        loadEv && st_ff.ptr == IRS_ADDR_LAST |=> st_ff.ptr == IRS_ADDR_FIRST;
    endproperty
    a_ptrWrap: assert property (p_ptrWrap)
        else $error("pointer did not roll over");

    property p_stream;
        s_ackGood |=> st_ff.state == ST_TXNEXT;
    endproperty
    a_stream: assert property (p_stream)
        else $error("acknowledged byte not followed by next byte");

    property p_nackRelease;
        st_ff.state == ST_TXACK && sclRise && st_ff.sdaSync
        && !startCond && !stopCond |=> st_ff.state == ST_WAIT && !sdaOe;
    endproperty
    a_nackRelease: assert property (p_nackRelease)
        else $error("link not released after not-acknowledge");

    property p_msbFirst;
        loadEv |=> sdaOe == ~st_ff.shift[7] && st_ff.bitCnt == IRS_BIT_ZERO;
    endproperty
    a_msbFirst: assert property (p_msbFirst)
        else $error("first bit sent is not the most significant");

    property p_volSel;
        loadEv && st_ff.ptr == IRS_ADDR_FIRST && st_ff.access_control_reg[IRS_ACR_VOL]
        |=> st_ff.shift == $past(st_ff.wiper[0]);
    endproperty
    a_volSel: assert property (p_volSel)
        else $error("wiper register not selected");
endmodule

`default_nettype wire

// ---- irs_read_sequencer_test.sv ----
// Self-checking bench for the I2C register read sequencer.
// Assumes irs_pkg and the controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module irs_read_sequencer_test;
    import irs_pkg::*;
    typedef struct packed {
        logic [7:0] access_control_reg, la, ld, addr;
        logic [4:0] n;
    } irs_row_t;
    localparam irs_row_t ROWS [0:5] = '{
        '{8'h00, 8'h04, 8'h3C, 8'h02, 5'h03},
        '{8'h00, 8'h0E, 8'h77, 8'h0E, 5'h04},
        '{8'h80, 8'h01, 8'h55, 8'h00, 5'h03},
        '{8'h00, 8'h02, 8'h99, 8'h00, 5'h03},
        '{8'hC0, 8'h0F, 8'h12, 8'h10, 5'h02},
        '{8'h00, 8'h05, 8'h01, 8'h00, 5'h11}};

    logic       clk_sys, rst, sclLine, sdaLine, sdaOut, sdaOe;
    logic       loadValid, loadReady, readActive;
    logic [2:0] strap;
    logic [7:0] loadAddr, loadData, acrSh, hdr;
    logic [7:0] ivr [0:3];
    logic [7:0] wr [0:3];
    logic [7:0] gp [0:15];
    int         errors, num_checks, cycles;

    irs_read_sequencer i_irs_read_sequencer (
        .clk_sys(clk_sys), .rst(rst), .sclIn(sclLine), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addr_select_pin_2(strap[2]),
        .addr_select_pin_1(strap[1]), .addr_select_pin_0(strap[0]),
        .loadValid(loadValid), .loadReady(loadReady), .loadAddr(loadAddr),
        .loadData(loadData), .readActive(readActive));

    irs_ctrl_model i_irs_ctrl_model (
        .clk_sys(clk_sys), .sdaOe(sdaOe), .sclLine(sclLine),
        .sdaLine(sdaLine));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic test_done();
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        num_checks++;
        if (seen !== expd) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, expd);
        end
    endtask

    task automatic init_shadow();
        acrSh = IRS_ACR_RESET;
        for (int i = 0; i < 16; i++) gp[i] = 8'h00;
        for (int i = 0; i < 4; i++) begin
            ivr[i] = 8'h00;
            wr[i] = 8'h00;
        end
    endtask

    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        if (a < 8'h04) return acrSh[IRS_ACR_VOL] ? wr[a[1:0]] : ivr[a[1:0]];
        if (a <= IRS_ADDR_LAST) return gp[a[3:0]];
        if (a == IRS_ADDR_ACR) return acrSh;
        return 8'h00;
    endfunction

    // Request held from a falling edge until a rising edge sees ready
    task automatic load_byte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        loadValid = 1'b1;
        loadAddr = a;
        loadData = d;
        while (loadReady !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        loadValid = 1'b0;
        if (a < 8'h04) begin
            wr[a[1:0]] = d;
            if (!acrSh[IRS_ACR_VOL]) ivr[a[1:0]] = d;
        end else if (a <= IRS_ADDR_LAST) gp[a[3:0]] = d;
        else if (a == IRS_ADDR_ACR) acrSh = d & IRS_ACR_WMASK;
    endtask

    task automatic run_read(input logic [7:0] addr, input int n);
        logic [7:0] p;
        logic       done;
        logic       seen;
        p = addr;
        done = 1'b0;
        seen = 1'b0;
        repeat (4) @(negedge clk_sys);
        // Watch the status output while the read streams
        fork
            begin
                i_irs_ctrl_model.read_regs({IRS_TYPE_CODE, strap, 1'b0},
                                           addr, n);
                done = 1'b1;
            end
            begin
                wait (readActive === 1'b1 || done);
                seen = readActive;
            end
        join
        check({7'h00, seen}, 8'h01);
        check({5'h00, i_irs_ctrl_model.acks}, 8'h07);
        for (int k = 0; k < n; k++) begin
            check(i_irs_ctrl_model.rxBuf[k], exp_byte(p));
            p = (p >= IRS_ADDR_LAST) ? 8'h00 : p + 8'h01;
        end
        check({7'h00, i_irs_ctrl_model.nackOe}, 8'h00);
        check({7'h00, readActive}, 8'h00);
    endtask

    initial begin
        cycles = 0;
        forever begin
            @(posedge clk_sys);
            cycles++;
            if (cycles == 60000) begin
                errors++;
                $display("CHECK FAILED at %0t: run hung", $time);
                test_done();
            end
        end
    end

    initial begin
        rst = 1'b1;
        loadValid = 1'b0;
        loadAddr = 8'h00;
        loadData = 8'h00;
        strap = 3'b101;
        errors = 0;
        num_checks = 0;
        init_shadow();
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        check({7'h00, sdaOe}, 8'h00);
        check({7'h00, sdaOut}, 8'h00);
        run_read(IRS_ADDR_ACR, 1);
        for (int i = 0; i < 16; i++) load_byte(8'(i), 8'hA0 + 8'(i));
        foreach (ROWS[r]) begin
            load_byte(IRS_ADDR_ACR, ROWS[r].access_control_reg);
            load_byte(ROWS[r].la, ROWS[r].ld);
            run_read(ROWS[r].addr, int'(ROWS[r].n));
        end
        // Second reset in mid-run must bring back the power-up contents
        @(negedge clk_sys);
        rst = 1'b1;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        init_shadow();
        repeat (4) @(negedge clk_sys);
        check({7'h00, loadReady}, 8'h01);
        run_read(8'h03, 2);
        // Foreign type code, then foreign straps: no answer at all
        for (int b = 0; b < 2; b++) begin
            hdr = (b == 0) ? {~IRS_TYPE_CODE, strap, 1'b0}
                           : {IRS_TYPE_CODE, ~strap, 1'b0};
            i_irs_ctrl_model.read_regs(hdr, 8'h02, 1);
            check({5'h00, i_irs_ctrl_model.acks}, 8'h00);
            check(i_irs_ctrl_model.rxBuf[0], 8'hFF);
        end
        run_read(8'h00, 1);
        test_done();
    end
endmodule

`default_nettype wire
